//--- src/wrs_pkg.sv
// Constants, types and state carriers for the watchdog, reset and wake supervisor
package wrs_pkg;
  // Clock and tick base
  localparam int CLK_NS = 8;
  localparam int TICK_US = 100;
  localparam int TICK_CYC_DEF = TICK_US * 1000 / CLK_NS;
  // Times in their own units, counts derived in ticks or cycles
  localparam int RST_DUR_US = 3400;
  localparam logic [11:0] RST_TICKS = 12'((RST_DUR_US + TICK_US - 1) / TICK_US);
  localparam int NREQ_MS = 350;
  localparam logic [11:0] NREQ_TICKS = 12'((NREQ_MS * 1000 + TICK_US - 1) / TICK_US);
  localparam int WD_P0_MS = 10;
  localparam int WD_P1_MS = 50;
  localparam int WD_P2_MS = 100;
  localparam int WD_P3_MS = 350;
  localparam logic [11:0] WD_T0 = 12'(WD_P0_MS * 1000 / TICK_US);
  localparam logic [11:0] WD_T1 = 12'(WD_P1_MS * 1000 / TICK_US);
  localparam logic [11:0] WD_T2 = 12'(WD_P2_MS * 1000 / TICK_US);
  localparam logic [11:0] WD_T3 = 12'(WD_P3_MS * 1000 / TICK_US);
  localparam int CYC_MS = 20;
  localparam logic [11:0] CYC_TICKS = 12'(CYC_MS * 1000 / TICK_US);
  localparam int TWAKE_MS = 100;
  localparam logic [11:0] TWAKE_TICKS = 12'(TWAKE_MS * 1000 / TICK_US);
  localparam int INT_NS = 10000;
  localparam logic [10:0] INT_CYC = 11'(INT_NS / CLK_NS);
  // Serial byte layout: address, write flag, data nibble
  localparam int SPI_ADR_LSB = 5;
  localparam int SPI_WR_BIT = 4;
  localparam logic [2:0] ADR_MCR = 3'h0;
  localparam logic [2:0] ADR_RCR = 3'h1;
  localparam logic [2:0] ADR_BUS = 3'h2;
  localparam logic [2:0] ADR_WUR = 3'h4;
  localparam logic [2:0] ADR_TIM = 3'h5;
  localparam logic [2:0] ADR_LPC = 3'h6;
  // Mode control codes
  localparam logic [2:0] MCR_DEBUG = 3'h0;
  localparam logic [2:0] MCR_NORM1 = 3'h1;
  localparam logic [2:0] MCR_STBY = 3'h2;
  localparam logic [2:0] MCR_STOP1 = 3'h3;
  localparam logic [2:0] MCR_SLEEP = 3'h4;
  localparam logic [2:0] MCR_NORM2 = 3'h5;
  localparam logic [2:0] MCR_STBY_DBG = 3'h6;
  localparam logic [2:0] MCR_STOP2 = 3'h7;
  // Field positions in the data nibble
  localparam int TIM_WIN = 2;
  localparam int RCR_SAFE = 1;
  localparam int RCR_WDSTOP = 3;
  localparam int LPC_AUTO = 0;
  localparam int LPC_TWAKE = 1;
  localparam int LPC_BIAS = 3;
  // Values after reset
  localparam logic [1:0] PER_RST = 2'h3;
  localparam logic WDSTOP_RST = 1'b1;
  // Pending low-power entry
  localparam logic [1:0] LP_NONE = 2'h0;
  localparam logic [1:0] LP_STOP = 2'h1;
  localparam logic [1:0] LP_SLEEP = 2'h2;

  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_NREQ = 6'h02,
    ST_NORMAL = 6'h04,
    ST_STANDBY = 6'h08,
    ST_STOP = 6'h10,
    ST_SLEEP = 6'h20
  } wrs_mode_t;

  typedef struct packed {
    wrs_mode_t mode;
    logic debug;
    logic [1:0] dbg_stage;
    logic from_sleep;
    logic [1:0] lp_pend;
    logic win_n;
    logic [1:0] per;
    logic rst_suppress;
    logic wdstop;
    logic [1:0] lvl;
    logic bias;
    logic auto_cyc;
    logic timed;
    logic [3:0] wake_src;
    logic bus_flag;
    logic supply_flag;
    logic wd_fail;
    logic wd_rst_flag;
    logic por_hold;
    logic [13:0] pre;
    logic [11:0] tmr;
    logic [11:0] wd_cnt;
    logic [11:0] cyc_cnt;
    logic [10:0] int_cnt;
    logic sw_on;
    logic [3:0] lv_prev;
    logic [1:0] vdd_s;
    logic [1:0] loss_s;
    logic [1:0] bus_s;
    logic [1:0] cs_s;
    logic [1:0] full_s;
    logic [3:0] lines_s1;
    logic [3:0] lines_s2;
    logic cs_prev;
    logic full_prev;
  } wrs_state_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sh;
    logic full;
  } wrs_link_t;
endpackage : wrs_pkg

//--- src/wrs_supervisor.sv
// Watchdog, reset and wake supervisor with its serial command receiver
`timescale 1ns/10ps
`default_nettype none
module wrs_supervisor import wrs_pkg::*; #(
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  input wire logic i_clk,              // System clock, 125 MHz
  input wire logic i_rst,              // Synchronous reset, high
  input wire logic i_ce,               // Clock enable, freezes state when low
  input wire logic i_sclk,             // Serial link clock from host
  input wire logic i_mosi,             // Serial data from host
  input wire logic i_chip_select_n,    // Frame select, low in frame
  input wire logic i_main_regulator_out_ok,          // Main regulator above threshold
  input wire logic i_supply_loss,      // Supply loss detector
  input wire logic [3:0] i_wake_lines, // Wake input lines
  input wire logic i_bus_wake,         // Bus transceiver wake request
  output logic o_reset_n,              // Reset output to host
  output logic o_wdog_fail_n,          // Watchdog failure output
  output logic o_interrupt_out_n,      // Wake interrupt pulse
  output logic o_supply_switch,        // Supply switch for line bias
  output logic o_main_reg_on,          // Main regulator enable
  output wrs_mode_t o_mode,            // Operating mode
  output logic o_debug,                // Debug mode active
  output logic [3:0] o_wake_src,       // Latched wake lines
  output logic o_bus_wake_flag,        // Latched bus wake
  output logic o_supply_loss_flag,     // Supply loss flag
  output logic o_wd_reset_flag,        // Watchdog failure occurred
  output logic o_safe_mode             // Reset suppress selected
);
  ////////////////////////////////////////////////////////////////////////////
  // Decoding used in several places
  function automatic logic [11:0] wd_period(input logic [1:0] sel);
    logic [11:0] p;
    p = WD_T3;
    case (sel)
      2'h0: p = WD_T0;
      2'h1: p = WD_T1;
      2'h2: p = WD_T2;
      default: p = WD_T3;
    endcase
    return p;
  endfunction : wd_period

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: byte receiver, cleared by the frame select itself
  wrs_link_t lk;
  wrs_link_t nx_lk;
  logic [7:0] link_hold;

  // Shift in MSB first, flag the byte after eight edges
  always_comb begin
    nx_lk = lk;
    nx_lk.sh = {lk.sh[5:0], i_mosi};
    nx_lk.cnt = lk.cnt + 3'h1;
    if (lk.cnt == 3'h7) begin
      nx_lk.full = 1'b1;
    end
  end

  // Clock stands between frames, so frame end clears the state
  always_ff @(posedge i_sclk or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      lk <= '0;
    end else begin
      lk <= nx_lk;
    end
  end

  // Held byte survives frame end; read only after the flag crossed
  always_ff @(posedge i_sclk) begin
    if (lk.cnt == 3'h7) begin
      link_hold <= {lk.sh, i_mosi};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main domain decode
  wrs_state_t st;
  wrs_state_t nx;
  logic tick;
  logic byte_new;
  logic [2:0] adr;
  logic wr;
  logic [3:0] dat;
  logic tim_wr;
  logic mcr_wr;
  logic rcr_wr;
  logic wur_wr;
  logic lpc_wr;
  logic mcr_rd;
  logic wur_rd;
  logic bus_rd;
  logic wd_run;
  logic wd_to;
  logic closed;
  logic wd_fail_ev;
  logic low_pw;
  logic cyc_on;
  logic direct;
  logic cyc_sense;
  logic cs_rise;
  logic tw_fire;
  logic wake;
  logic vdd;
  logic [3:0] ev_dir;
  logic [3:0] ev_lines;

  assign tick = (st.pre == 14'(TICK_CYC - 1));
  assign byte_new = st.full_s[1] & ~st.full_prev;
  assign adr = link_hold[7:SPI_ADR_LSB];
  assign wr = link_hold[SPI_WR_BIT];
  assign dat = link_hold[3:0];
  assign tim_wr = byte_new & wr & (adr == ADR_TIM);
  assign mcr_wr = byte_new & wr & (adr == ADR_MCR);
  assign rcr_wr = byte_new & wr & (adr == ADR_RCR);
  assign wur_wr = byte_new & wr & (adr == ADR_WUR);
  assign lpc_wr = byte_new & wr & (adr == ADR_LPC);
  assign mcr_rd = byte_new & ~wr & (adr == ADR_MCR);
  assign wur_rd = byte_new & ~wr & (adr == ADR_WUR);
  assign bus_rd = byte_new & ~wr & (adr == ADR_BUS);
  assign vdd = st.vdd_s[1];
  assign wd_run = ((st.mode == ST_NORMAL) | (st.mode == ST_STANDBY) |
                   ((st.mode == ST_STOP) & st.wdstop)) & ~st.debug;
  assign wd_to = wd_run & tick & (st.wd_cnt >= wd_period(st.per) - 12'h001);
  assign closed = ~st.win_n & (st.wd_cnt < (wd_period(st.per) >> 1));
  assign wd_fail_ev = wd_to | (tim_wr & wd_run & closed);
  assign low_pw = (st.mode == ST_STOP) | (st.mode == ST_SLEEP);
  assign cyc_on = st.bias & st.auto_cyc;
  assign direct = ~st.bias & ~st.auto_cyc;
  // sample at end of bias pulse
  assign cyc_sense = cyc_on & st.sw_on & tick;
  assign cs_rise = st.cs_s[1] & ~st.cs_prev;
  assign tw_fire = st.timed & tick & (st.cyc_cnt == TWAKE_TICKS - 12'h001);

  for (genvar g = 0; g < 4; g++) begin : g_lvl
    assign ev_dir[g] = (st.lines_s2[g] == st.lvl[g / 2]);
  end

  assign ev_lines = !low_pw ? 4'h0 :
                    direct ? ev_dir :
                    cyc_sense ? (st.lines_s2 ^ st.lv_prev) : 4'h0;
  assign wake = low_pw & ((|ev_lines) | st.bus_s[1] | cs_rise | tw_fire);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    nx = st;
    // Two-stage synchronisers; only stage two feeds logic
    nx.vdd_s = {st.vdd_s[0], i_main_regulator_out_ok};
    nx.loss_s = {st.loss_s[0], i_supply_loss};
    nx.bus_s = {st.bus_s[0], i_bus_wake};
    nx.cs_s = {st.cs_s[0], i_chip_select_n};
    nx.full_s = {st.full_s[0], lk.full};
    nx.lines_s1 = i_wake_lines;
    nx.lines_s2 = st.lines_s1;
    nx.cs_prev = st.cs_s[1];
    nx.full_prev = st.full_s[1];
    nx.pre = tick ? 14'h0000 : st.pre + 14'h0001;
    if (st.int_cnt != 11'h000) begin
      nx.int_cnt = st.int_cnt - 11'h001;
    end
    // Read clears first so a coincident set still wins
    if (mcr_rd) begin
      nx.supply_flag = 1'b0;
    end
    if (st.loss_s[1]) begin
      nx.supply_flag = 1'b1;
    end
    if (wur_rd) begin
      nx.wake_src = 4'h0;
    end
    if (bus_rd) begin
      nx.bus_flag = 1'b0;
    end
    if (rcr_wr) begin
      nx.rst_suppress = dat[RCR_SAFE];
      nx.wdstop = dat[RCR_WDSTOP];
    end
    if (wur_wr) begin
      nx.lvl = dat[1:0];
    end
    if (lpc_wr) begin
      nx.bias = dat[LPC_BIAS];
      nx.auto_cyc = dat[LPC_AUTO];
      nx.timed = dat[LPC_TWAKE] & ~(dat[LPC_BIAS] & dat[LPC_AUTO]);
    end
    if (wd_run & tick) begin
      nx.wd_cnt = st.wd_cnt + 12'h001;
    end
    unique case (st.mode)
      ST_RESET: begin
        if (!vdd) begin
          nx.tmr = 12'h000;
        end else if (tick) begin
          nx.tmr = st.tmr + 12'h001;
          if (st.tmr == RST_TICKS - 12'h001) begin
            nx.mode = ST_NREQ;
            nx.tmr = 12'h000;
            nx.por_hold = 1'b0;
          end
        end
      end
      ST_NREQ: begin
        if (tick) begin
          nx.tmr = st.tmr + 12'h001;
        end
        if (tick && st.tmr == NREQ_TICKS - 12'h001) begin
          nx.tmr = 12'h000;
          nx.dbg_stage = 2'h0;
          // debug wake must pick a mode
          nx.mode = (st.from_sleep && !st.debug) ? ST_SLEEP : ST_RESET;
        end else if (tim_wr) begin
          nx.win_n = dat[TIM_WIN];
          nx.per = dat[1:0];
          nx.wd_cnt = 12'h000;
          nx.wd_fail = 1'b0;
          if (st.supply_flag && !st.debug) begin
            nx.dbg_stage = 2'h1;
          end else begin
            nx.mode = ST_NORMAL;
            nx.from_sleep = 1'b0;
          end
        end else if (mcr_wr) begin
          if (st.dbg_stage == 2'h1 && dat == 4'h0) begin
            nx.dbg_stage = 2'h2;
          end else if (st.dbg_stage == 2'h2 && dat[2:0] == MCR_NORM2) begin
            nx.mode = ST_NORMAL;
            nx.debug = 1'b1;
            nx.dbg_stage = 2'h0;
            nx.from_sleep = 1'b0;
          end else if (st.dbg_stage != 2'h0 && dat[2:0] == MCR_NORM1) begin
            nx.mode = ST_NORMAL;
            nx.dbg_stage = 2'h0;
            nx.from_sleep = 1'b0;
          end else if (st.debug && dat[2:0] == MCR_NORM2) begin
            nx.mode = ST_NORMAL;
            nx.from_sleep = 1'b0;
          end else if (st.debug && dat[2:0] == MCR_STBY_DBG) begin
            nx.mode = ST_STANDBY;
            nx.from_sleep = 1'b0;
          end
        end
      end
      ST_NORMAL, ST_STANDBY: begin
        if (tim_wr) begin
          nx.win_n = dat[TIM_WIN];
          nx.per = dat[1:0];
          nx.wd_cnt = 12'h000;
          nx.wd_fail = 1'b0;
        end
        if (mcr_wr) begin
          case (dat[2:0])
            MCR_DEBUG: begin
              nx.debug = 1'b0;
              nx.wd_cnt = 12'h000;
            end
            MCR_NORM1, MCR_NORM2: nx.mode = ST_NORMAL;
            MCR_STBY, MCR_STBY_DBG: nx.mode = ST_STANDBY;
            MCR_STOP1, MCR_STOP2: nx.lp_pend = LP_STOP;
            MCR_SLEEP: nx.lp_pend = st.supply_flag ? LP_NONE : LP_SLEEP;
          endcase
        end
        // Entry waits for frame end so its own select edge is not a wake
        if (st.lp_pend != LP_NONE && st.cs_s[1] && !mcr_wr) begin
          nx.mode = (st.lp_pend == LP_STOP) ? ST_STOP : ST_SLEEP;
          nx.lp_pend = LP_NONE;
          nx.cyc_cnt = 12'h000;
          nx.sw_on = 1'b0;
          nx.lv_prev = st.lines_s2;
        end
      end
      ST_STOP, ST_SLEEP: begin
        if (tick && cyc_on) begin
          nx.cyc_cnt = st.cyc_cnt + 12'h001;
          nx.sw_on = 1'b0;
          if (st.cyc_cnt == CYC_TICKS - 12'h001) begin
            nx.cyc_cnt = 12'h000;
            nx.sw_on = 1'b1;
          end
        end else if (tick && st.timed) begin
          nx.cyc_cnt = st.cyc_cnt + 12'h001;
        end
        if (cyc_sense) begin
          nx.lv_prev = st.lines_s2;
        end
        nx.wake_src = nx.wake_src | ev_lines;
        nx.bus_flag = nx.bus_flag | st.bus_s[1];
        if (wake) begin
          nx.sw_on = 1'b0;
          nx.tmr = 12'h000;
          if (st.mode == ST_SLEEP) begin
            nx.mode = ST_RESET;
            nx.from_sleep = 1'b1;
          end else begin
            nx.mode = ST_NREQ;
            nx.from_sleep = 1'b0;
            nx.int_cnt = INT_CYC;
          end
        end
      end
      default: begin
        nx.mode = ST_RESET;
        nx.tmr = 12'h000;
      end
    endcase
    // failure output and mode 1 reset
    if (wd_fail_ev) begin
      nx.wd_fail = 1'b1;
      nx.wd_rst_flag = 1'b1;
      nx.wd_cnt = 12'h000;
      if (!st.rst_suppress) begin
        nx.mode = ST_RESET;
        nx.tmr = 12'h000;
      end
    end
    if (!vdd && st.mode != ST_SLEEP) begin
      nx.mode = ST_RESET;
      nx.tmr = 12'h000;
    end
  end

  // State register; reset values are the power-up defaults
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
      st.mode <= ST_RESET;
      st.per <= PER_RST;
      st.wdstop <= WDSTOP_RST;
      st.supply_flag <= 1'b1;
      st.por_hold <= 1'b1;
    end else if (i_ce) begin
      st <= nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all decoded from registered state
  assign o_reset_n = ~((st.mode == ST_RESET) | (st.mode == ST_SLEEP));
  // fail output low until first release
  assign o_wdog_fail_n = ~(st.wd_fail | st.por_hold);
  assign o_interrupt_out_n = (st.int_cnt == 11'h000);
  assign o_supply_switch = st.sw_on;
  assign o_main_reg_on = (st.mode != ST_SLEEP);
  assign o_mode = st.mode;
  assign o_debug = st.debug;
  assign o_wake_src = st.wake_src;
  assign o_bus_wake_flag = st.bus_flag;
  assign o_supply_loss_flag = st.supply_flag;
  assign o_wd_reset_flag = st.wd_rst_flag;
  assign o_safe_mode = st.rst_suppress;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  mode1_timeout_a: assert property (wd_to && i_ce && !st.rst_suppress |=>
    !o_reset_n && !o_wdog_fail_n) else $error("mode 1 time-out without reset");
  safe_timeout_a: assert property (wd_to && i_ce && st.rst_suppress && vdd
    |=> o_reset_n && !o_wdog_fail_n) else $error("safe time-out misbehaved");
  closed_clear_a: assert property (tim_wr && wd_run && closed && i_ce |=>
    st.wd_fail) else $error("closed window clear accepted");
  vdd_low_a: assert property (!vdd && st.mode != ST_SLEEP && i_ce |=>
    !o_reset_n) else $error("reset high during undervoltage");
  nreq_expire_a: assert property (st.mode == ST_NREQ && tick && i_ce && vdd
    && st.tmr == NREQ_TICKS - 12'h001 && !st.from_sleep && !wd_fail_ev
    |=> st.mode == ST_RESET) else $error("no reset after request time-out");
  stop_wake_a: assert property (st.mode == ST_STOP && wake && i_ce && vdd
    && !wd_fail_ev |=> st.mode == ST_NREQ && !o_interrupt_out_n [*8])
    else $error("stop wake without interrupt pulse");
  cs_wake_a: assert property (st.mode == ST_SLEEP && cs_rise && i_ce
    |=> st.mode == ST_RESET && st.from_sleep) else $error("select edge missed");
  wake_mutex_a: assert property (!(st.timed && st.bias && st.auto_cyc))
    else $error("timed and cyclic wake both on");
  debug_nowd_a: assert property (st.debug && st.mode == ST_NORMAL
    |-> !wd_run) else $error("watchdog running in debug");

  stop_wake_c: cover property (st.mode == ST_STOP ##1 st.mode == ST_NREQ);
  debug_enter_c: cover property (st.dbg_stage == 2'h2 ##1 st.debug);
  safe_fail_c: cover property (wd_to && st.rst_suppress);
endmodule : wrs_supervisor
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the watchdog, reset and wake supervisor
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module tb import wrs_pkg::*;;
  logic i_clk, i_rst, i_main_regulator_out_ok, sclk, mosi, csn, ce, supply_loss, bus_wake;
  logic o_supply_switch, o_main_reg_on, o_debug, o_bus_wake_flag, o_supply_loss_flag;
  logic [3:0] i_wake_lines;
  logic o_reset_n, o_wdog_fail_n, o_interrupt_out_n, o_wd_reset_flag, o_safe_mode;
  logic [3:0] o_wake_src;
  wrs_mode_t o_mode;
  int error_cnt = 0;
  int checked = 0;
  // Short tick keeps every ms figure cheap to simulate
  wrs_supervisor #(.TICK_CYC(4)) wrs_supervisor_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
    .i_sclk(sclk), .i_mosi(mosi), .i_chip_select_n(csn), .i_main_regulator_out_ok(i_main_regulator_out_ok),
    .i_supply_loss(supply_loss), .i_wake_lines(i_wake_lines), .i_bus_wake(bus_wake),
    .o_reset_n(o_reset_n), .o_wdog_fail_n(o_wdog_fail_n),
    .o_interrupt_out_n(o_interrupt_out_n), .o_supply_switch(o_supply_switch),
    .o_main_reg_on(o_main_reg_on), .o_mode(o_mode), .o_debug(o_debug),
    .o_wake_src(o_wake_src), .o_bus_wake_flag(o_bus_wake_flag),
    .o_supply_loss_flag(o_supply_loss_flag), .o_wd_reset_flag(o_wd_reset_flag),
    .o_safe_mode(o_safe_mode));
  wrs_host_model wrs_host_model_i (.i_clk(i_clk), .o_sclk(sclk), .o_mosi(mosi),
    .o_chip_select_n(csn));
  // 125 MHz system clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  //////////////////////////////////////////
  task automatic results();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  function automatic logic [5:0] pick(input int sel);
    case (sel)
      0: return {5'h00, o_reset_n};
      1: return {5'h00, o_wdog_fail_n};
      default: return o_mode;
    endcase
  endfunction : pick
  // Bounded wait; running out ends the run as a failure
  task automatic wait_on(input int sel, input logic [5:0] v, input int lim);
    int n;
    for (n = 0; n < lim && pick(sel) !== v; n++) begin
      @(posedge i_clk);
      #1;
    end
    if (pick(sel) !== v) begin
      error_cnt++;
      $display("unexpected wait %0d: expected %0h seen %0h", sel, v, pick(sel));
      results();
    end
  endtask : wait_on
  //////////////////////////////////////////
  task automatic t_power();
    repeat (200) @(posedge i_clk);
    #1;
    `CHK("reset_n", 1'b0, o_reset_n)
    `CHK("fail_n", 1'b0, o_wdog_fail_n)
    `CHK("mode", ST_RESET, o_mode)
    `CHK("safe", 1'b0, o_safe_mode)
    `CHK("loss flag", 1'b1, o_supply_loss_flag)
    `CHK("reg on", 1'b1, o_main_reg_on)
    `CHK("debug", 1'b0, o_debug)
    `CHK("switch", 1'b0, o_supply_switch)
    @(posedge i_clk) i_main_regulator_out_ok <= 1'b1;
    wait_on(0, 6'h01, 300);
    `CHK("fail_n up", 1'b1, o_wdog_fail_n)
    `CHK("mode", ST_NREQ, o_mode)
  endtask : t_power
  task automatic t_vdd_nreq();
    @(posedge i_clk) i_main_regulator_out_ok <= 1'b0;
    repeat (5) @(posedge i_clk);
    #1;
    `CHK("reset_n", 1'b0, o_reset_n)
    `CHK("fail_n", 1'b1, o_wdog_fail_n)
    @(posedge i_clk) i_main_regulator_out_ok <= 1'b1;
    wait_on(0, 6'h01, 300);
    repeat (13900) @(posedge i_clk);
    #1;
    `CHK("nreq held", ST_NREQ, o_mode)
    wait_on(2, ST_RESET, 200);
    wait_on(0, 6'h01, 300);
  endtask : t_vdd_nreq
  task automatic t_mode1();
    wrs_host_model_i.send_byte(8'h00);
    `CHK("loss clr", 1'b0, o_supply_loss_flag)
    wrs_host_model_i.send_byte(8'hB4);
    `CHK("mode", ST_NORMAL, o_mode)
    repeat (370) @(posedge i_clk);
    #1;
    `CHK("early", 1'b1, o_reset_n)
    wait_on(0, 6'h00, 60);
    `CHK("fail_n", 1'b0, o_wdog_fail_n)
    `CHK("flag", 1'b1, o_wd_reset_flag)
    wait_on(0, 6'h01, 300);
    `CHK("fail held", 1'b0, o_wdog_fail_n)
    wrs_host_model_i.send_byte(8'hB4);
    `CHK("fail clr", 1'b1, o_wdog_fail_n)
  endtask : t_mode1
  task automatic t_window();
    // Window select with the fastest period, then clear again at once
    repeat (240) @(posedge i_clk);
    wrs_host_model_i.send_byte(8'hB0);
    wrs_host_model_i.send_byte(8'hB0);
    wait_on(0, 6'h00, 20);
    wait_on(0, 6'h01, 300);
    wrs_host_model_i.send_byte(8'hB0);
    repeat (240) @(posedge i_clk);
    wrs_host_model_i.send_byte(8'hB0);
    `CHK("open clr", 1'b1, o_wdog_fail_n)
    `CHK("mode", ST_NORMAL, o_mode)
  endtask : t_window
  task automatic t_safe();
    wrs_host_model_i.send_byte(8'h32);
    `CHK("safe", 1'b1, o_safe_mode)
    wait_on(1, 6'h00, 600);
    `CHK("reset_n", 1'b1, o_reset_n)
    `CHK("mode", ST_NORMAL, o_mode)
    // A clear sent while the enable is low must be lost
    @(posedge i_clk) ce <= 1'b0;
    wrs_host_model_i.send_byte(8'hB4);
    @(posedge i_clk) ce <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    `CHK("frozen", 1'b0, o_wdog_fail_n)
  endtask : t_safe
  task automatic t_stop();
    int n;
    wrs_host_model_i.send_byte(8'h91);
    wrs_host_model_i.send_byte(8'h13);
    wait_on(2, ST_STOP, 20);
    repeat (20) @(posedge i_clk);
    #1;
    `CHK("no wake", ST_STOP, o_mode)
    @(posedge i_clk) i_wake_lines <= 4'h4;
    wait_on(2, ST_NREQ, 20);
    `CHK("int", 1'b0, o_interrupt_out_n)
    `CHK("src", 4'h8, o_wake_src)
    for (n = 0; n < 2000 && o_interrupt_out_n === 1'b0; n++) begin
      @(posedge i_clk);
      #1;
    end
    `CHK("int len", INT_CYC, 11'(n))
    @(posedge i_clk) i_wake_lines <= 4'hC;
    wrs_host_model_i.send_byte(8'hB4);
    wrs_host_model_i.send_byte(8'h13);
    wait_on(2, ST_STOP, 20);
    wrs_host_model_i.send_byte(8'h40);
    `CHK("cs wake", ST_NREQ, o_mode)
    // Bus wake from stop sets its own flag
    wrs_host_model_i.send_byte(8'hB4);
    wrs_host_model_i.send_byte(8'h13);
    wait_on(2, ST_STOP, 20);
    `CHK("bus flag", 1'b0, o_bus_wake_flag)
    @(posedge i_clk) bus_wake <= 1'b1;
    wait_on(2, ST_NREQ, 20);
    `CHK("bus flag", 1'b1, o_bus_wake_flag)
    @(posedge i_clk) bus_wake <= 1'b0;
  endtask : t_stop
  //////////////////////////////////////////
  // Main sequence
  initial begin
    i_rst = 1'b1;
    i_main_regulator_out_ok = 1'b0;
    i_wake_lines = 4'hC;
    ce = 1'b1;
    supply_loss = 1'b0;
    bus_wake = 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    t_power();
    t_vdd_nreq();
    t_mode1();
    t_window();
    t_safe();
    t_stop();
    results();
  end
endmodule : tb
`default_nettype wire

//--- test/wrs_host_model.sv
// Host model: sends one-byte serial frames to the supervisor
`timescale 1ns/10ps
`default_nettype none
module wrs_host_model (
  input wire logic i_clk,        // System clock, paces frame gaps
  output logic o_sclk,           // Link clock, still between frames
  output logic o_mosi,           // Serial data, MSB first
  output logic o_chip_select_n   // Frame select, low in frame
);
  // Idle levels at time zero
  initial begin
    o_sclk = 1'b0;
    o_mosi = 1'b0;
    o_chip_select_n = 1'b1;
  end
  //////////////////////////////////////////
  // one write or read per frame
  // Gaps of 5 cycles cover the 2-flop crossing on both sides of a frame
  task automatic send_byte(input logic [7:0] b);
    int k;
    @(posedge i_clk);
    o_chip_select_n <= 1'b0;
    for (k = 7; k >= 0; k--) begin
      o_mosi = b[k];
      #3 o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
    end
    // Released data line must not look like a held bit
    o_mosi = ~o_mosi;
    repeat (5) @(posedge i_clk);
    o_chip_select_n <= 1'b1;
    repeat (5) @(posedge i_clk);
  endtask : send_byte
endmodule : wrs_host_model
`default_nettype wire
